/* core/canid_slice.sv */
/*
 transmit identifier storage, first bit timing register and can pin control
 behind an apb slave. assumes the frame engine drives tx_bit_dominant and
 consumes the assembled identifier, and that pins outside resolve enables.
*/
`timescale 1ns/1ns
`default_nettype none
// Function
// - extended select set sends 29-bit id, standard bits become id 28..18.
// - extended select clear sends 11-bit id, ignores extended bits 17..0.
// - low register bits 7..5 hold standard 2..0 or extended 20..18.
// - extended select at bit 3, extended bits 17..16 at bits 1..0.
// - extended high register holds bits 15..8, unused for standard frames.
// - low register bits 4 and 2, pin control bits 3..1 read zero.
// - jump width equals field plus one quanta, 1 to 4.
// - quantum is 2*(prescaler+1) clock periods, 2 to 128.
// - aux source set outputs can clock, clear copies main transmit.
// - aux enable set drives aux pin, clear leaves general-purpose io.
// - drive-high set drives recessive high, clear tri-states recessive.
// - capture enable routes message-received to capture unit one.
// - clock source set selects oscillator, clear selects pll.
// - timing and pin control reset to zero, identifiers undefined.
module canid_slice
(
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        osc_clk_en,
   input  wire logic        pll_clk_en,
   input  wire logic        tx_bit_dominant,
   input  wire logic        msg_received,
   input  wire logic        port_c_pin_two,
   input  wire logic        gpio_aux_out,
   input  wire logic        gpio_aux_oe,
   output logic             main_tx_pin_out,
   output logic             main_tx_pin_oe,
   output logic             aux_tx_pin_out,
   output logic             aux_tx_pin_oe,
   output logic             capture_unit_one_in,
   output logic [28:0]      tx_identifier,
   output logic             tx_extended,
   output logic [2:0]       resync_jump_width,
   output logic             quantum_tick,
   output logic [2:0]       op_mode
);
   logic [7:0]                 ident_low_q;
   logic [7:0]                 ident_high_q;
   logic [7:0]                 ext_high_q;
   logic [7:0]                 ext_low_q;
   canid_pkg::canid_timing_t   timing_q;
   canid_pkg::canid_pins_t     pins_q;
   logic [2:0]                 mode_q;
   logic                       wr_en;
   logic                       rd_en;
   logic                       known;
   logic                       cfg_mode;
   logic                       can_clk_en;
   logic                       can_clk_q;
   logic [1:0]                 pin_sync_q;
   logic [7:0]                 rd_byte;

   assign pready  = 1'b1;
   assign wr_en   = psel && penable && pwrite;
   assign rd_en   = psel && penable && !pwrite;
   assign cfg_mode = (mode_q == canid_pkg::MODE_CONFIG);
   assign op_mode = mode_q;

   always_comb
   begin
      known = 1'b1;
      rd_byte = 8'h00;
      unique case (paddr)
         canid_pkg::OFF_IDENT_LOW:  rd_byte = ident_low_q & canid_pkg::IDENT_LOW_MASK;
         canid_pkg::OFF_EXT_HIGH:   rd_byte = ext_high_q;
         canid_pkg::OFF_TIMING_ONE: rd_byte = timing_q;
         canid_pkg::OFF_PIN_CTRL:   rd_byte = pins_q & canid_pkg::PIN_CTRL_MASK;
         canid_pkg::OFF_IDENT_HIGH: rd_byte = ident_high_q;
         canid_pkg::OFF_EXT_LOW:    rd_byte = ext_low_q;
         canid_pkg::OFF_MODE:       rd_byte = {5'h00, mode_q};
         canid_pkg::OFF_STATUS:     rd_byte = {7'h00, can_clk_q};
         default:                   known = 1'b0;
      endcase
   end

   assign pslverr = psel && penable && !known;

   always_ff @(posedge clk)
   begin
      if (!rst_n)
         prdata <= 32'h0000_0000;
      else if (rd_en)
         prdata <= {24'h00_0000, rd_byte};
   end

   // identifiers have no reset value: left undefined like the storage cells
   always_ff @(posedge clk)
   begin
      if (wr_en && paddr == canid_pkg::OFF_IDENT_LOW)
         ident_low_q <= pwdata[7:0] & canid_pkg::IDENT_LOW_MASK;
      if (wr_en && paddr == canid_pkg::OFF_EXT_HIGH)
         ext_high_q <= pwdata[7:0];
      if (wr_en && paddr == canid_pkg::OFF_IDENT_HIGH)
         ident_high_q <= pwdata[7:0];
      if (wr_en && paddr == canid_pkg::OFF_EXT_LOW)
         ext_low_q <= pwdata[7:0];
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
         timing_q <= canid_pkg::TIMING_RESET;
      else if (wr_en && paddr == canid_pkg::OFF_TIMING_ONE && cfg_mode)
         timing_q <= pwdata[7:0];
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
         pins_q <= canid_pkg::PIN_RESET;
      else if (wr_en && paddr == canid_pkg::OFF_PIN_CTRL)
         pins_q <= pwdata[7:0] & canid_pkg::PIN_CTRL_MASK;
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
         mode_q <= canid_pkg::MODE_RESET;
      else if (wr_en && paddr == canid_pkg::OFF_MODE)
         mode_q <= pwdata[2:0];
   end

   // identifier assembly for the frame engine
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         tx_identifier <= 29'h0000_0000;
         tx_extended   <= 1'b0;
      end
      else
      begin
         tx_extended <= ident_low_q[canid_pkg::POS_EXT_SEL];
         if (ident_low_q[canid_pkg::POS_EXT_SEL])
            tx_identifier <= {ident_high_q, ident_low_q[7:5], ident_low_q[1:0],
                              ext_high_q, ext_low_q};
         else
            tx_identifier <= {18'h0_0000, ident_high_q, ident_low_q[7:5]};
      end
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
         resync_jump_width <= 3'h1;
      else
         resync_jump_width <= {1'b0, timing_q.jump_code} + 3'h1;
   end

   // clock choice: both sources arrive as enables on the one clock
   assign can_clk_en = pins_q.can_clock_source ? osc_clk_en : pll_clk_en;

   canid_quantum u_quantum
   (
      .clk           (clk),
      .rst_n         (rst_n),
      .can_clk_en    (can_clk_en),
      .prescale_code (timing_q.prescale_code),
      .quantum_tick  (quantum_tick)
   );

   // can clock for the aux pin toggles on each selected enable
   always_ff @(posedge clk)
   begin
      if (!rst_n)
         can_clk_q <= 1'b0;
      else if (can_clk_en)
         can_clk_q <= !can_clk_q;
   end

   // pin input from outside: two flops before use
   always_ff @(posedge clk)
   begin
      if (!rst_n)
         pin_sync_q <= 2'h0;
      else
         pin_sync_q <= {pin_sync_q[0], port_c_pin_two};
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
         capture_unit_one_in <= 1'b0;
      else if (pins_q.receive_capture_enable)
         capture_unit_one_in <= msg_received;
      else
         capture_unit_one_in <= pin_sync_q[1];
   end

   // recessive is high; tri-state recessive avoids fighting a wired bus
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         main_tx_pin_out <= 1'b1;
         main_tx_pin_oe  <= 1'b0;
      end
      else
      begin
         main_tx_pin_out <= !tx_bit_dominant;
         main_tx_pin_oe  <= tx_bit_dominant || pins_q.recessive_drive_high;
      end
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         aux_tx_pin_out <= 1'b0;
         aux_tx_pin_oe  <= 1'b0;
      end
      else if (pins_q.aux_tx_pin_enable)
      begin
         aux_tx_pin_out <= pins_q.aux_tx_source_select ? can_clk_q : !tx_bit_dominant;
         aux_tx_pin_oe  <= 1'b1;
      end
      else
      begin
         aux_tx_pin_out <= gpio_aux_out;
         aux_tx_pin_oe  <= gpio_aux_oe;
      end
   end

   a_timing_locked: assert property (@(posedge clk) disable iff (!rst_n)
      (wr_en && paddr == canid_pkg::OFF_TIMING_ONE && !cfg_mode) |=> $stable(timing_q))
      else $error("timing written outside config mode");
   a_timing_write: assert property (@(posedge clk) disable iff (!rst_n)
      (wr_en && paddr == canid_pkg::OFF_TIMING_ONE && cfg_mode)
      |=> timing_q == $past(pwdata[7:0])) else $error("timing write lost");
   a_jump_width: assert property (@(posedge clk) disable iff (!rst_n)
      ##1 resync_jump_width == {1'b0, $past(timing_q.jump_code)} + 3'h1)
      else $error("jump width wrong");
   a_std_ident: assert property (@(posedge clk) disable iff (!rst_n)
      !ident_low_q[3] |=> tx_identifier[28:11] == 18'h0_0000 && !tx_extended)
      else $error("standard id carries extended bits");
   a_ext_ident: assert property (@(posedge clk) disable iff (!rst_n)
      ident_low_q[3] |=> tx_identifier[17:16] == $past(ident_low_q[1:0]) && tx_extended)
      else $error("extended bits misplaced");
   a_low_zero: assert property (@(posedge clk) disable iff (!rst_n)
      (rd_en && paddr == canid_pkg::OFF_IDENT_LOW) |=> prdata[4] == 1'b0 && prdata[2] == 1'b0)
      else $error("reserved id bits nonzero");
   a_pin_zero: assert property (@(posedge clk) disable iff (!rst_n)
      (rd_en && paddr == canid_pkg::OFF_PIN_CTRL) |=> prdata[3:1] == 3'h0)
      else $error("reserved pin bits nonzero");
   a_recessive_drive: assert property (@(posedge clk) disable iff (!rst_n)
      (!tx_bit_dominant && !pins_q.recessive_drive_high) |=> !main_tx_pin_oe)
      else $error("recessive not tri-stated");
   a_capture_route: assert property (@(posedge clk) disable iff (!rst_n)
      pins_q.receive_capture_enable |=> capture_unit_one_in == $past(msg_received))
      else $error("capture not routed");
   a_aux_copy: assert property (@(posedge clk) disable iff (!rst_n)
      (pins_q.aux_tx_pin_enable && !pins_q.aux_tx_source_select)
      |=> aux_tx_pin_out == !$past(tx_bit_dominant) && aux_tx_pin_oe)
      else $error("aux pin not copying main");
   a_aux_clock: assert property (@(posedge clk) disable iff (!rst_n)
      (pins_q.aux_tx_pin_enable && pins_q.aux_tx_source_select)
      |=> aux_tx_pin_out == $past(can_clk_q) && aux_tx_pin_oe)
      else $error("aux pin not showing can clock");
   a_clock_source: assert property (@(posedge clk) disable iff (!rst_n)
      (pins_q.can_clock_source && osc_clk_en) |=> can_clk_q != $past(can_clk_q))
      else $error("oscillator not selected");

   c_ext_frame: cover property (@(posedge clk) disable iff (!rst_n) tx_extended);
   c_timing_cfg: cover property (@(posedge clk) disable iff (!rst_n)
      wr_en && paddr == canid_pkg::OFF_TIMING_ONE && cfg_mode);
   c_aux_clock: cover property (@(posedge clk) disable iff (!rst_n)
      pins_q.aux_tx_pin_enable && pins_q.aux_tx_source_select);
endmodule // canid_slice
`default_nettype wire

/* core/canid_pkg.sv */
/*
 package for the transmit identifier, bit timing and pin control slice:
 register offsets, field positions, reset values, carrier structs.
 assumes a 32-bit apb master with one aligned word per register.
*/
package canid_pkg;
   localparam logic [7:0] OFF_IDENT_LOW   = 8'h00;
   localparam logic [7:0] OFF_EXT_HIGH    = 8'h04;
   localparam logic [7:0] OFF_TIMING_ONE  = 8'h08;
   localparam logic [7:0] OFF_PIN_CTRL    = 8'h0c;
   localparam logic [7:0] OFF_IDENT_HIGH  = 8'h10;
   localparam logic [7:0] OFF_EXT_LOW     = 8'h14;
   localparam logic [7:0] OFF_MODE        = 8'h18;
   localparam logic [7:0] OFF_STATUS      = 8'h1c;

   localparam int POS_EXT_SEL   = 3;
   localparam int POS_AUX_SRC   = 7;
   localparam int POS_AUX_EN    = 6;
   localparam int POS_DRIVE_HI  = 5;
   localparam int POS_CAPTURE   = 4;
   localparam int POS_CLK_SRC   = 0;

   localparam logic [7:0] IDENT_LOW_MASK = 8'heb;
   localparam logic [7:0] PIN_CTRL_MASK  = 8'hf1;
   localparam logic [7:0] TIMING_RESET   = 8'h00;
   localparam logic [7:0] PIN_RESET      = 8'h00;
   localparam logic [2:0] MODE_CONFIG    = 3'h4;
   localparam logic [2:0] MODE_RESET     = 3'h4;

   typedef struct packed {
      logic [1:0] jump_code;
      logic [5:0] prescale_code;
   } canid_timing_t;

   typedef struct packed {
      logic       aux_tx_source_select;
      logic       aux_tx_pin_enable;
      logic       recessive_drive_high;
      logic       receive_capture_enable;
      logic [2:0] unused;
      logic       can_clock_source;
   } canid_pins_t;
endpackage

/* core/canid_quantum.sv */
/*
 time quantum divider: one-cycle enable every 2*(code+1) can clock cycles.
 assumes the code is stable while it runs; a change restarts the count.
*/
`timescale 1ns/1ns
`default_nettype none
module canid_quantum
(
   input  wire logic       clk,
   input  wire logic       rst_n,
   input  wire logic       can_clk_en,
   input  wire logic [5:0] prescale_code,
   output logic            quantum_tick
);
   logic [6:0] count_q;
   logic [6:0] last_q;
   logic [5:0] code_q;

   assign last_q = {prescale_code, 1'b1};

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         count_q      <= 7'h00;
         code_q       <= 6'h00;
         quantum_tick <= 1'b0;
      end
      else
      begin
         code_q       <= prescale_code;
         quantum_tick <= 1'b0;
         if (code_q != prescale_code)
            count_q <= 7'h00;
         else if (can_clk_en)
         begin
            if (count_q == last_q)
            begin
               count_q      <= 7'h00;
               quantum_tick <= 1'b1;
            end
            else
               count_q <= count_q + 7'h01;
         end
      end
   end

   a_tick_spacing: assert property (@(posedge clk) disable iff (!rst_n)
      quantum_tick |=> !quantum_tick) else $error("quantum tick too close");
endmodule // canid_quantum
`default_nettype wire

/* tb/canid_bus_model.sv */
/*
 bus side of the main transmit pin: resolves driven level or pull-up.
 assumes the transceiver input sees recessive high when the pin floats.
*/
`timescale 1ns/1ns
`default_nettype none
module canid_bus_model
(
   input  wire logic main_tx_pin_out,
   input  wire logic main_tx_pin_oe,
   output logic      bus_level
);
   // floating pin reads recessive, so a missed drive-high stays hidden here
   assign bus_level = main_tx_pin_oe ? main_tx_pin_out : 1'b1;
endmodule // canid_bus_model
`default_nettype wire

/* tb/can_tx_id_bit_timing_io_tb.sv */
/*
 self-checking bench for canid_slice: apb register traffic, pin and tick checks.
 assumes zero wait states may change; every wait is bounded by a count.
*/
`timescale 1ns/1ns
`default_nettype none
module can_tx_id_bit_timing_io_tb;
   logic        clk, rst_n, psel, penable, pwrite, pready, pslverr;
   logic [7:0]  paddr, eh;
   logic [31:0] pwdata, prdata;
   logic        osc_en, pll_en, dom, msg, pin2, gout, goe;
   logic        mo, moe, ao, aoe, cap, ext, tick, bus;
   logic [28:0] txid;
   logic [2:0]  rjw, mode;
   logic [31:0] q[$];
   int          bad_count, n_checks, n;

   canid_slice dut (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .osc_clk_en(osc_en), .pll_clk_en(pll_en), .tx_bit_dominant(dom), .msg_received(msg),
      .port_c_pin_two(pin2), .gpio_aux_out(gout), .gpio_aux_oe(goe),
      .main_tx_pin_out(mo), .main_tx_pin_oe(moe), .aux_tx_pin_out(ao), .aux_tx_pin_oe(aoe),
      .capture_unit_one_in(cap), .tx_identifier(txid), .tx_extended(ext),
      .resync_jump_width(rjw), .quantum_tick(tick), .op_mode(mode));
   canid_bus_model model (.main_tx_pin_out(mo), .main_tx_pin_oe(moe), .bus_level(bus));

   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         bad_count++;
         $display("ERROR %0t got %h exp %h", $time, got, exp);
      end
   endtask

   task conclude;
      if (bad_count == 0 && n_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   // read data is registered at the access edge, so look just after it
   always @(posedge clk)
      if (psel && penable && !pwrite && pready && !pslverr)
      begin
         #1;
         chk(prdata, q.pop_front());
      end

   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic e);
      int k = 0;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1 && k++ < 20);
      chk({31'h0, pslverr}, {31'h0, e});
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      apb(1'b1, a, {24'h0, d}, 1'b0);
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      q.push_back({24'h0, e});
      apb(1'b0, a, 32'h0, 1'b0);
   endtask

   // edges from one tick to the next; 300 means no tick was seen
   task automatic tq(input int per);
      int k = 0;
      int c = 0;
      while (tick !== 1'b1 && k++ < 300) @(posedge clk);
      do
      begin
         @(posedge clk);
         c++;
      end
      while (tick !== 1'b1 && c < 300);
      chk(32'(c), 32'(per));
   endtask

   initial
   begin
      {rst_n, psel, penable, pwrite, paddr, pwdata} = '0;
      {osc_en, pll_en, dom, msg, pin2, gout, goe} = '0;
      n = $urandom(32'h32bc);
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      rd(8'h08, 8'h00);
      rd(8'h0c, 8'h00);
      chk(32'(rjw), 32'h1);
      eh = 8'($urandom);
      wr(8'h10, 8'ha5);
      wr(8'h04, eh);
      wr(8'h14, 8'h3c);
      wr(8'h00, 8'hff);
      rd(8'h00, 8'heb);
      rd(8'h04, eh);
      chk(32'(ext), 32'h1);
      chk(32'(txid), {3'h0, 8'ha5, 3'h7, 2'h3, eh, 8'h3c});
      wr(8'h00, 8'h04);
      // the flag updates at the edge the write task returns on: look mid-cycle
      @(negedge clk);
      chk(32'(ext), 32'h0);
      @(posedge clk);
      rd(8'h00, 8'h00);
      for (int j = 0; j < 4; j++)
      begin
         wr(8'h08, {2'(j), 6'h2a});
         rd(8'h08, {2'(j), 6'h2a});
         chk(32'(rjw), 32'(j + 1));
      end
      pll_en <= 1'b1;
      foreach (q[i]) n = i;
      for (int c = 0; c < 64; c += 21)
      begin
         wr(8'h08, 8'(c));
         tq(2 * (c + 1));
      end
      wr(8'h0c, 8'h01);
      tq(300);
      osc_en <= 1'b1;
      pll_en <= 1'b0;
      tq(128);
      wr(8'h18, 8'h00);
      wr(8'h08, 8'h55);
      rd(8'h08, 8'h3f);
      wr(8'h18, 8'h04);
      // drive-high on, as a differential bus needs
      wr(8'h0c, 8'hff);
      rd(8'h0c, 8'hf1);
      msg <= 1'b1;
      repeat (3) @(posedge clk);
      chk({29'h0, moe, mo, bus}, 32'h7);
      chk(32'(cap), 32'h1);
      wr(8'h0c, 8'h61);
      dom <= 1'b1;
      msg <= 1'b0;
      pin2 <= 1'b1;
      repeat (4) @(posedge clk);
      chk({28'h0, aoe, ao, moe, mo}, 32'ha);
      chk(32'(cap), 32'h1);
      wr(8'h0c, 8'h00);
      dom <= 1'b0;
      gout <= 1'b1;
      goe <= 1'b1;
      repeat (3) @(posedge clk);
      chk({28'h0, moe, bus, aoe, ao}, 32'h7);
      apb(1'b1, 8'h20, 32'h0, 1'b1);
      apb(1'b0, 8'h20, 32'h0, 1'b1);
      conclude;
   end

   initial
   begin
      #100000;
      bad_count++;
      conclude;
   end
endmodule // can_tx_id_bit_timing_io_tb
`default_nettype wire
